//--- ppe_ctrl_decode.sv
// Register-to-control decoder with registered outputs
`timescale 1ns/1ps

module ppe_ctrl_decode
  import ppe_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register contents and context
  input wire ppe_regs_t regs,
  input wire ppe_pointer_t pointer,
  input wire logic double_tag_enable,
  // Controls
  output ppe_ctrl_t ctrl
);

  ppe_ctrl_t state;
  ppe_ctrl_t next_state;
  logic en;
  logic blind;

  always_comb begin
    en = regs.policing[PPE_POL_ENABLE];
    blind = regs.policing[PPE_POL_MODE_BLIND];
    next_state = state;
    next_state.police_active = en; // R1
    next_state.early_drop_active = en; // R1
    next_state.color_blind = en & blind; // R2
    next_state.color_aware = en & ~blind; // R2
    next_state.srp_drop_allowed = en & regs.policing[PPE_POL_DROP_SRP]; // R3
    next_state.color_remap = en & ~blind & regs.policing[PPE_POL_REMAP]; // R4
    next_state.color_mark = en & regs.policing[PPE_POL_MARK]; // R5
    next_state.non_ip_frame_color = regs.policing[PPE_POL_NONIP_LO +: 2]; // R6
    next_state.per_port_policing = regs.policing[PPE_POL_PORT_BASED]; // R7
    // Aggregate rates live under port index zero
    next_state.rate_port_select = regs.policing[PPE_POL_PORT_BASED] ?
      pointer.port_index : PPE_AGGREGATE_PORT; // R7
    next_state.monitor_type = ppe_mon_type_t'(regs.policing[PPE_POL_PKT_TYPE_LO +: 2]); // R8
    next_state.monitor_port = pointer.port_index; // R9 R16
    next_state.monitor_queue = pointer.queue_pointer; // R9 R16
    next_state.drop_all_over_max = en & regs.policing[PPE_POL_DROP_ALL]; // R10
    next_state.drop_by_probability = en & ~regs.policing[PPE_POL_DROP_ALL]; // R10
    next_state.count_dropped_only = regs.policing[PPE_POL_DROPPED_COLOR]; // R11
    next_state.tx_queue_index = regs.txq_index; // R12
    next_state.inner_vid_replace = regs.vid_replace & ~double_tag_enable; // R14
    next_state.outer_vid_replace = regs.vid_replace & double_tag_enable; // R15
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= '0;
      state.non_ip_frame_color <= PPE_POL_RESET[PPE_POL_NONIP_LO +: 2];
    end else begin
      state <= next_state;
    end
  end

  assign ctrl = state;

endmodule

//--- ppe_pkg.sv
// Package: register map, reset values and carriers of the port policing and egress control block
package ppe_pkg;

  // ----------------------------------------
  // Register map (byte offsets inside the port block)
  // ----------------------------------------
  localparam logic [11:0] PPE_OFF_POLICING = 12'h80c;
  localparam logic [11:0] PPE_OFF_TXQ_SEL = 12'h900;
  localparam logic [11:0] PPE_OFF_TXQ_SEL_BYTE = 12'h903;
  localparam logic [11:0] PPE_OFF_VID_REPLACE = 12'h904;
  localparam logic [11:0] PPE_OFF_VID_REPLACE_BYTE = 12'h907;
  localparam int PPE_PORT_SHIFT = 12;
  localparam int PPE_ADDR_W = 16;
  localparam int PPE_BYTE_LANE_SHIFT = 24;

  // ----------------------------------------
  // Field positions of the policing control register
  // ----------------------------------------
  localparam int PPE_POL_ENABLE = 0;
  localparam int PPE_POL_MODE_BLIND = 1;
  localparam int PPE_POL_DROP_SRP = 2;
  localparam int PPE_POL_REMAP = 3;
  localparam int PPE_POL_MARK = 4;
  localparam int PPE_POL_NONIP_LO = 5;
  localparam int PPE_POL_PORT_BASED = 7;
  localparam int PPE_POL_PKT_TYPE_LO = 8;
  localparam int PPE_POL_DROP_ALL = 10;
  localparam int PPE_POL_DROPPED_COLOR = 11;
  localparam int PPE_POL_WIDTH = 12;
  localparam int PPE_TXQ_WIDTH = 2;
  localparam int PPE_VID_WIDTH = 1;

  // ----------------------------------------
  // Values after reset
  // ----------------------------------------
  localparam logic [11:0] PPE_POL_RESET = 12'h020;
  localparam logic [1:0] PPE_TXQ_RESET = 2'h0;
  localparam logic PPE_VID_RESET = 1'b0;
  localparam logic [2:0] PPE_AGGREGATE_PORT = 3'h0;

  // Monitor counter selection
  typedef enum logic [1:0] {
    PPE_MON_DROPPED = 2'b00,
    PPE_MON_GREEN = 2'b01,
    PPE_MON_YELLOW = 2'b10,
    PPE_MON_RED = 2'b11
  } ppe_mon_type_t;

  // Software-visible register contents
  typedef struct packed {
    logic [11:0] policing;
    logic [1:0] txq_index;
    logic vid_replace;
  } ppe_regs_t;

  // Qualified controls toward the forwarding engine
  typedef struct packed {
    logic police_active;
    logic early_drop_active;
    logic color_blind;
    logic color_aware;
    logic srp_drop_allowed;
    logic color_remap;
    logic color_mark;
    logic [1:0] non_ip_frame_color;
    logic per_port_policing;
    logic [2:0] rate_port_select;
    ppe_mon_type_t monitor_type;
    logic [2:0] monitor_port;
    logic [1:0] monitor_queue;
    logic drop_all_over_max;
    logic drop_by_probability;
    logic count_dropped_only;
    logic [1:0] tx_queue_index;
    logic inner_vid_replace;
    logic outer_vid_replace;
  } ppe_ctrl_t;

  // Pointer register fields supplied from outside
  typedef struct packed {
    logic [2:0] port_index;
    logic [1:0] queue_pointer;
  } ppe_pointer_t;

endpackage

//--- ppe_port_policing_egress_ctrl.sv
// Top: APB register bank for per-port policing, early drop and egress controls
//
// Notes on behaviour
// R1: The enable bit turns policing and early drop on together and resets to zero.
// R2: With policing on, mode one is colour-blind and mode zero colour-aware.
// R3: Stream reservation packets may be early-dropped only when the drop-SRP bit is one.
// R4: In colour-aware operation the remap bit remaps the DSCP colour, else it is used as is.
// R5: Policing result colour is marked into DSCP only when the mark bit is set.
// R6: Non-IP frames in colour-aware mode take the two-bit colour field, reset 01b.
// R7: Port-based bit gives per-port per-queue policing, else aggregate rates at port index zero.
// R8: Packet-type field selects the early-drop monitor counter: red, yellow, green or dropped.
// R9: Monitor reads address the queue and port given by the pointer register.
// R10: Drop-all drops everything above the maximum threshold, else drop by probability.
// R11: Dropped-colour bit makes the colour counters count only dropped packets.
// R12: The two-bit transmit queue index, reset zero, selects the queue of indexed registers.
// R13: The queue index can also be reached as one byte at the word's highest byte address.
// R14: VID replacement swaps any non-zero egress VLAN ID for the port default one.
// R15: With double tagging the outer service tag ID is replaced instead of the inner one.
// R16: Port index and queue pointer from the pointer register pick the indirect entry.
// R17: Reserved bits read zero and ignore writes; one instance sits at each port block base.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps

module ppe_port_policing_egress_ctrl
  import ppe_pkg::*;
#(
  parameter logic [3:0] PORT_NUM = 4'h1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PPE_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Context from neighbouring registers
  input wire ppe_pointer_t pointer,
  input wire logic double_tag_enable,
  // Controls toward the forwarding engine
  output ppe_ctrl_t ctrl
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    ppe_regs_t regs;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } ppe_state_t;

  typedef enum logic [2:0] {
    PPE_SEL_NONE,
    PPE_SEL_POLICING,
    PPE_SEL_TXQ,
    PPE_SEL_TXQ_BYTE,
    PPE_SEL_VID,
    PPE_SEL_VID_BYTE
  } ppe_sel_t;

  ppe_state_t state;
  ppe_state_t next_state;
  ppe_sel_t sel;
  logic [31:0] wmask;
  logic [31:0] merged;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic ppe_sel_t decode(input logic [PPE_ADDR_W-1:0] addr);
    ppe_sel_t s;
    s = PPE_SEL_NONE;
    if (addr[PPE_ADDR_W-1:PPE_PORT_SHIFT] == PORT_NUM) begin // R17
      case (addr[PPE_PORT_SHIFT-1:0])
        PPE_OFF_POLICING: s = PPE_SEL_POLICING;
        PPE_OFF_TXQ_SEL: s = PPE_SEL_TXQ;
        PPE_OFF_TXQ_SEL_BYTE: s = PPE_SEL_TXQ_BYTE; // R13
        PPE_OFF_VID_REPLACE: s = PPE_SEL_VID;
        PPE_OFF_VID_REPLACE_BYTE: s = PPE_SEL_VID_BYTE;
        default: s = PPE_SEL_NONE;
      endcase
    end
    return s;
  endfunction

  // Byte strobes to bit mask
  function automatic logic [31:0] strobe_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_state = state;
    sel = decode(paddr);
    wmask = strobe_mask(pstrb);
    merged = '0;
    next_state.ready = 1'b0;
    if (psel && !penable) begin
      // Setup cycle: prepare the answer for the access phase
      next_state.ready = 1'b1;
      next_state.err = (sel == PPE_SEL_NONE);
      next_state.rdata = '0;
      case (sel)
        PPE_SEL_POLICING: next_state.rdata[PPE_POL_WIDTH-1:0] = state.regs.policing; // R17
        PPE_SEL_TXQ: next_state.rdata[PPE_TXQ_WIDTH-1:0] = state.regs.txq_index;
        PPE_SEL_TXQ_BYTE: begin
          next_state.rdata[PPE_BYTE_LANE_SHIFT +: PPE_TXQ_WIDTH] = state.regs.txq_index; // R13
        end
        PPE_SEL_VID: next_state.rdata[0] = state.regs.vid_replace;
        PPE_SEL_VID_BYTE: next_state.rdata[PPE_BYTE_LANE_SHIFT] = state.regs.vid_replace;
        default: next_state.rdata = '0;
      endcase
      if (pwrite) begin
        next_state.rdata = '0;
      end
    end else if (psel && penable && state.ready) begin
      // Access edge: the write takes effect here only
      next_state.rdata = '0;
      next_state.err = 1'b0;
      if (pwrite) begin
        case (sel)
          PPE_SEL_POLICING: begin
            merged = (32'(state.regs.policing) & ~wmask) | (pwdata & wmask);
            next_state.regs.policing = merged[PPE_POL_WIDTH-1:0]; // R1 R17
          end
          PPE_SEL_TXQ: begin
            if (pstrb[0]) begin
              next_state.regs.txq_index = pwdata[PPE_TXQ_WIDTH-1:0]; // R12
            end
          end
          PPE_SEL_TXQ_BYTE: begin
            if (pstrb[3]) begin
              next_state.regs.txq_index = pwdata[PPE_BYTE_LANE_SHIFT +: PPE_TXQ_WIDTH]; // R13
            end
          end
          PPE_SEL_VID: begin
            if (pstrb[0]) begin
              next_state.regs.vid_replace = pwdata[0]; // R14
            end
          end
          PPE_SEL_VID_BYTE: begin
            if (pstrb[3]) begin
              next_state.regs.vid_replace = pwdata[PPE_BYTE_LANE_SHIFT];
            end
          end
          default: next_state.regs = state.regs;
        endcase
      end
    end else begin
      next_state.rdata = '0;
      next_state.err = 1'b0;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= '0;
      state.regs.policing <= PPE_POL_RESET; // R1 R6
      state.regs.txq_index <= PPE_TXQ_RESET; // R12
      state.regs.vid_replace <= PPE_VID_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign prdata = state.rdata;
  assign pready = state.ready;
  assign pslverr = state.err;

  // ----------------------------------------
  // Control decode
  // ----------------------------------------
  ppe_ctrl_decode u_decode (
    .ref_clk(ref_clk),
    .reset(reset),
    .regs(state.regs),
    .pointer(pointer),
    .double_tag_enable(double_tag_enable),
    .ctrl(ctrl)
  );

endmodule

//--- ppe_port_policing_egress_ctrl_assertions.sv
// Checker: bus answer and control relations of the policing register bank
`timescale 1ns/1ps

module ppe_checker
  import ppe_pkg::*;
#(
  parameter logic [3:0] PORT_NUM = 4'h1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PPE_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Context and controls
  input wire ppe_pointer_t pointer,
  input wire logic double_tag_enable,
  input wire ppe_ctrl_t ctrl
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  property p_answer; psel && !penable |=> pready ##1 !pready; endproperty
  a_answer: assert property (p_answer) else $error("no single answer cycle");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("error answer malformed");
  property p_enable; ctrl.police_active == ctrl.early_drop_active; endproperty
  a_enable: assert property (p_enable) else $error("enables differ");
  property p_mode;
    (ctrl.color_blind ^ ctrl.color_aware) == ctrl.police_active;
  endproperty
  a_mode: assert property (p_mode) else $error("colour mode wrong");
  property p_remap; ctrl.color_remap |-> ctrl.color_aware; endproperty
  a_remap: assert property (p_remap) else $error("remap outside aware");
  property p_gate;
    ctrl.srp_drop_allowed || ctrl.color_mark |-> ctrl.police_active;
  endproperty
  a_gate: assert property (p_gate) else $error("control without enable");
  property p_rate; !ctrl.per_port_policing |-> ctrl.rate_port_select == 3'h0; endproperty
  a_rate: assert property (p_rate) else $error("aggregate port wrong");
  property p_mon;
    !$past(reset) && $stable(pointer) |->
      ctrl.monitor_port == pointer.port_index && ctrl.monitor_queue == pointer.queue_pointer;
  endproperty
  a_mon: assert property (p_mon) else $error("monitor select wrong");
  property p_drop;
    (ctrl.drop_all_over_max ^ ctrl.drop_by_probability) == ctrl.police_active;
  endproperty
  a_drop: assert property (p_drop) else $error("drop policy wrong");
  property p_vid; !(ctrl.inner_vid_replace && ctrl.outer_vid_replace); endproperty
  a_vid: assert property (p_vid) else $error("both tags replaced");
  property p_txq;
    psel && penable && pready && pwrite && pstrb[0] && paddr == {PORT_NUM, PPE_OFF_TXQ_SEL}
      |-> ##2 ctrl.tx_queue_index == $past(pwdata[1:0], 2);
  endproperty
  a_txq: assert property (p_txq) else $error("queue index not applied");

  c_write: cover property (psel && penable && pready && pwrite);
  c_err: cover property (pslverr);
  c_outer: cover property (ctrl.outer_vid_replace);
endmodule

bind ppe_port_policing_egress_ctrl ppe_checker #(.PORT_NUM(PORT_NUM)) i_chk (
  .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pointer(pointer), .double_tag_enable(double_tag_enable), .ctrl(ctrl));

//--- ppe_port_policing_egress_ctrl_test.sv
// Testbench: register access and control outputs of the policing register bank
`timescale 1ns/1ps

module ppe_port_policing_egress_ctrl_test
  import ppe_pkg::*;
;
  logic ref_clk, reset, psel, penable, pwrite, dt, pready, pslverr, v;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, seed, r;
  logic [3:0] pstrb;
  logic [11:0] p;
  logic [1:0] q;
  ppe_pointer_t ptr;
  ppe_ctrl_t ctrl;
  logic [32:0] exp_q[$];
  int miscompares, n_tests, cyc;

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  ppe_port_policing_egress_ctrl i_dut (.ref_clk(ref_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pointer(ptr),
    .double_tag_enable(dt), .ctrl(ctrl));

  task automatic end_of_test();
    $display("comparisons %0d, miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] e);
    n_tests++;
    if (seen !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, e, seen);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic ppe_ctrl_t model();
    ppe_ctrl_t c;
    c.police_active = p[0];
    c.early_drop_active = p[0];
    c.color_blind = p[0] & p[1];
    c.color_aware = p[0] & ~p[1];
    c.srp_drop_allowed = p[0] & p[2];
    c.color_remap = p[0] & ~p[1] & p[3];
    c.color_mark = p[0] & p[4];
    c.non_ip_frame_color = p[6:5];
    c.per_port_policing = p[7];
    c.rate_port_select = p[7] ? ptr.port_index : 3'h0;
    c.monitor_type = ppe_mon_type_t'(p[9:8]);
    c.monitor_port = ptr.port_index;
    c.monitor_queue = ptr.queue_pointer;
    c.drop_all_over_max = p[0] & p[10];
    c.drop_by_probability = p[0] & ~p[10];
    c.count_dropped_only = p[11];
    c.tx_queue_index = q;
    c.inner_vid_replace = v & ~dt;
    c.outer_vid_replace = v & dt;
    return c;
  endfunction

  // ----------------------------------------
  // Bus driver and answer monitor
  // ----------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [32:0] e, input logic [3:0] pn = 4'h1);
    @(posedge ref_clk);
    exp_q.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {pn, a};
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (pready === 1'b1 && exp_q.size() > 0) check("answer", {pslverr, prdata}, exp_q.pop_front());
    if (cyc == 6000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic cmp_ctrl();
    repeat (3) @(posedge ref_clk);
    check("ctrl", {4'h0, ctrl}, {4'h0, model()});
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, dt, paddr, pwdata, pstrb, ptr} = '0;
    seed = 32'h2ebe;
    {p, q, v} = {12'h020, 2'h0, 1'b0};
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    cmp_ctrl();
    apb(0, PPE_OFF_POLICING, 0, 0, 33'h20);
    apb(0, PPE_OFF_TXQ_SEL, 0, 0, 33'h0);
    apb(0, PPE_OFF_VID_REPLACE, 0, 0, 33'h0);
    $display("reset test done");
    apb(1, PPE_OFF_POLICING, '1, 4'hf, 33'h0);
    apb(1, PPE_OFF_TXQ_SEL, '1, 4'hf, 33'h0);
    apb(1, PPE_OFF_VID_REPLACE, '1, 4'hf, 33'h0);
    apb(0, PPE_OFF_POLICING, 0, 0, 33'hfff);
    apb(0, PPE_OFF_TXQ_SEL, 0, 0, 33'h3);
    apb(0, PPE_OFF_VID_REPLACE, 0, 0, 33'h1);
    {p, q, v} = {12'hfff, 2'h3, 1'b1};
    cmp_ctrl();
    apb(1, PPE_OFF_POLICING, 0, 4'h2, 33'h0);
    apb(0, PPE_OFF_POLICING, 0, 0, 33'h0ff);
    apb(1, PPE_OFF_TXQ_SEL_BYTE, 32'h01000000, 4'h8, 33'h0);
    apb(0, PPE_OFF_TXQ_SEL, 0, 0, 33'h1);
    apb(0, PPE_OFF_TXQ_SEL_BYTE, 0, 0, 33'h01000000);
    apb(1, PPE_OFF_TXQ_SEL, '1, 4'he, 33'h0);
    apb(0, PPE_OFF_TXQ_SEL, 0, 0, 33'h1);
    apb(1, PPE_OFF_VID_REPLACE, 0, 4'h0, 33'h0);
    apb(0, PPE_OFF_VID_REPLACE_BYTE, 0, 0, 33'h01000000);
    apb(1, PPE_OFF_VID_REPLACE_BYTE, 0, 4'h8, 33'h0);
    apb(0, PPE_OFF_VID_REPLACE, 0, 0, 33'h0);
    $display("access test done");
    apb(1, PPE_OFF_POLICING, 0, 4'hf, {1'b1, 32'h0}, 4'h2);
    apb(0, PPE_OFF_POLICING, 0, 0, {1'b1, 32'h0}, 4'h2);
    apb(1, 12'h908, '1, 4'hf, {1'b1, 32'h0});
    apb(0, PPE_OFF_POLICING, 0, 0, 33'h0ff);
    {p, q, v} = {12'h0ff, 2'h1, 1'b0};
    cmp_ctrl();
    $display("unmapped test done");
    for (int i = 0; i < 32; i++) begin
      r = rnd();
      ptr <= r[20:16];
      dt <= r[21];
      p = r[11:0];
      apb(1, PPE_OFF_POLICING, r, 4'hf, 33'h0);
      r = rnd();
      q = r[1:0];
      v = r[2];
      apb(1, PPE_OFF_TXQ_SEL, r, 4'hf, 33'h0);
      apb(1, PPE_OFF_VID_REPLACE, r >> 2, 4'hf, 33'h0);
      apb(0, PPE_OFF_POLICING, 0, 0, {21'h0, p});
      cmp_ctrl();
    end
    $display("random test done");
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    {p, q, v} = {12'h020, 2'h0, 1'b0};
    apb(0, PPE_OFF_POLICING, 0, 0, 33'h20);
    apb(0, PPE_OFF_TXQ_SEL, 0, 0, 33'h0);
    apb(0, PPE_OFF_VID_REPLACE, 0, 0, 33'h0);
    cmp_ctrl();
    $display("second reset test done");
    check("answers left", 33'(exp_q.size()), 33'h0);
    end_of_test();
  end
endmodule
